// >>> fbp_pkg.sv
// constants and carrier types for the floppy base and port sharing registers
package fbp_pkg;

  // configuration indices of the two registers
  localparam logic [7:0] FBP_IDX_BASE = 8'h20;
  localparam logic [7:0] FBP_IDX_SHARE = 8'h21;

  // reset values
  localparam logic [7:0] FBP_BASE_RESET = 8'h3C;
  localparam logic [7:0] FBP_SHARE_RESET = 8'h00;
  localparam logic [7:0] FBP_INDEX_RESET = 8'h00;

  // writable bits of each register
  localparam logic [7:0] FBP_BASE_MASK = 8'hFC;
  localparam logic [7:0] FBP_SHARE_MASK = 8'h07;

  // field positions
  localparam int FBP_BASE_LSB = 2;
  localparam int FBP_BASE_MSB = 7;
  localparam int FBP_SHARE_LSB = 0;
  localparam int FBP_SHARE_MSB = 1;
  localparam int FBP_TMO_SEL_BIT = 2;

  // sharing field encodings
  localparam logic [1:0] FBP_SHARE_MODE_REG = 2'h0;
  localparam logic [1:0] FBP_SHARE_DRV1 = 2'h1;
  localparam logic [1:0] FBP_SHARE_BOTH = 2'h2;
  localparam logic [1:0] FBP_SHARE_RSVD = 2'h3;

  // configuration port access from the host side logic
  typedef struct packed {
    logic       cfg_active;
    logic       index_wr;
    logic       data_wr;
    logic       data_rd;
    logic [7:0] wdata;
  } fbp_cfg_req_t;

  // host i/o cycle seen by the floppy decoder
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } fbp_io_req_t;

  // parallel port pin ownership
  typedef struct packed {
    logic pp_is_floppy;
    logic drive0_on_pp;
    logic drive1_on_pp;
  } fbp_route_t;

endpackage : fbp_pkg

// >>> fbp_sync.sv
// two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
module fbp_sync (
  input wire logic clk_i,     // system clock
  input wire logic resetn_i,  // async reset, active low
  input wire logic async_i,   // level from outside the clock domain
  output logic sync_o         // synchronised level
);

  logic stage_one;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      stage_one <= 1'b1;
      sync_o <= 1'b1;
    end
    else
    begin
      stage_one <= async_i;
      sync_o <= stage_one;
    end
  end

endmodule : fbp_sync

// >>> fbp_regs.sv
// floppy base address and floppy-on-printer-port configuration registers
//
// Function
// - base register reached only in configuration state with index 20H.
// - floppy base may sit at 48 eight-byte slots from 100H to 3F0H.
// - base bits nine and eight both zero disables all floppy decoding.
// - select when A[15:10] zero, A[9:4] match base, A3 zero.
// - base register resets to 3CH on main supply power-on reset.
// - base register bits 2..7 hold address bits 4..9 for comparator.
// - base register bits 0 and 1 are read-only and read zero.
// - sharing register reached only in configuration state with index 21H.
// - sharing field zero ignores pin; port mode register bits decide.
// - field 01 with pin low: drive 0 dedicated, drive 1 on port.
// - field 10 with pin low: both drives on printer port pins.
// - select bit zero clears timeout flag at end of status read.
// - select bit one clears timeout flag only on write of one.
// - sharing register resets to 00H; bits 3 to 7 read zero.
`timescale 1ns/1ps
module fbp_regs (
  input wire logic clk_i,                   // 20 MHz system clock
  input wire logic resetn_i,                // power-on reset, active low
  input wire fbp_pkg::fbp_cfg_req_t cfg_i,  // configuration port access
  input wire fbp_pkg::fbp_io_req_t io_i,    // host i/o cycle address
  input wire logic share_pin_i,             // floppy_share_select pin
  input wire logic pp_mode_floppy_i,        // port mode asks for floppy
  input wire logic tmo_event_i,             // epp timeout detected, pulse
  input wire logic tmo_status_rd_i,         // epp status read, level
  input wire logic tmo_write_one_i,         // write of one to timeout bit
  output logic [7:0] rdata_o,               // configuration read data
  output logic rd_hit_o,                    // read hit one of our registers
  output logic fdc_sel_o,                   // floppy controller selected
  output logic [2:0] fdc_reg_o,             // floppy internal register
  output fbp_pkg::fbp_route_t route_o,      // printer port pin ownership
  output logic tmo_flag_o                   // epp timeout flag
);

  ////////////////////////////////////////////////////////////////////////////
  // storage and helpers

  logic [7:0] config_index;
  logic [7:0] base_reg;
  logic [7:0] share_reg;
  logic share_pin_sync;
  logic status_rd_prev;
  logic base_hit;
  logic share_hit;
  logic fdc_enabled;
  logic [1:0] share_field;
  logic tmo_clear;
  fbp_pkg::fbp_route_t next_route;

  // true when an access in configuration state targets the given index
  function automatic logic cfg_hit(input fbp_pkg::fbp_cfg_req_t req,
                                   input logic [7:0] idx,
                                   input logic [7:0] want);
    cfg_hit = req.cfg_active && (idx == want);
  endfunction : cfg_hit

  // the sharing pin comes from a board pin, so it is synchronised first
  fbp_sync u_share_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .async_i(share_pin_i),
    .sync_o(share_pin_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // configuration index and register access

  // index latches on every index write while in configuration state
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      config_index <= fbp_pkg::FBP_INDEX_RESET;
    else if (cfg_i.cfg_active && cfg_i.index_wr)
      config_index <= cfg_i.wdata;
  end

  assign base_hit = cfg_hit(cfg_i, config_index, fbp_pkg::FBP_IDX_BASE);
  assign share_hit = cfg_hit(cfg_i, config_index, fbp_pkg::FBP_IDX_SHARE);

  // base register; low bits are masked so stray ones never reach decode
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      base_reg <= fbp_pkg::FBP_BASE_RESET;
    else if (base_hit && cfg_i.data_wr)
      base_reg <= cfg_i.wdata & fbp_pkg::FBP_BASE_MASK;
  end

  // sharing register with timeout clear select
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      share_reg <= fbp_pkg::FBP_SHARE_RESET;
    else if (share_hit && cfg_i.data_wr)
      share_reg <= cfg_i.wdata & fbp_pkg::FBP_SHARE_MASK;
  end

  // read data is registered; other indices answer zero with no hit
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rdata_o <= 8'h00;
      rd_hit_o <= 1'b0;
    end
    else
    begin
      rd_hit_o <= cfg_i.data_rd && (base_hit || share_hit);
      if (cfg_i.data_rd && base_hit)
        rdata_o <= base_reg;
      else if (cfg_i.data_rd && share_hit)
        rdata_o <= share_reg;
      else
        rdata_o <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // floppy address decode

  // bits nine and eight both zero disable
  assign fdc_enabled = |base_reg[fbp_pkg::FBP_BASE_MSB -: 2];

  // registered select; the compare covers 48 slots from 100H to 3F0H
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      fdc_sel_o <= 1'b0;
      fdc_reg_o <= 3'h0;
    end
    else
    begin
      // upper bits zero, base match, bit 3 zero
      fdc_sel_o <= io_i.valid && fdc_enabled
                   && (io_i.addr[15:10] == 6'h00)
                   && (io_i.addr[9:4] ==
                       base_reg[fbp_pkg::FBP_BASE_MSB:fbp_pkg::FBP_BASE_LSB])
                   && !io_i.addr[3];
      fdc_reg_o <= io_i.addr[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // printer port pin routing

  assign share_field =
    share_reg[fbp_pkg::FBP_SHARE_MSB:fbp_pkg::FBP_SHARE_LSB];

  // pin is active low; reserved code falls back to plain printer port use
  always_comb
  begin
    next_route = '0;
    unique case (share_field)
      fbp_pkg::FBP_SHARE_MODE_REG:
      begin
        next_route.pp_is_floppy = pp_mode_floppy_i;
        next_route.drive1_on_pp = pp_mode_floppy_i;
      end
      fbp_pkg::FBP_SHARE_DRV1:
      begin
        next_route.pp_is_floppy = !share_pin_sync;
        next_route.drive1_on_pp = !share_pin_sync;
      end
      fbp_pkg::FBP_SHARE_BOTH:
      begin
        next_route.pp_is_floppy = !share_pin_sync;
        next_route.drive0_on_pp = !share_pin_sync;
        next_route.drive1_on_pp = !share_pin_sync;
      end
      fbp_pkg::FBP_SHARE_RSVD:
        next_route = '0;
    endcase
  end

  // routing leaves through a register so the pins never glitch
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      route_o <= '0;
    else
      route_o <= next_route;
  end

  ////////////////////////////////////////////////////////////////////////////
  // epp timeout flag

  // remember the read level to find its trailing edge
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      status_rd_prev <= 1'b0;
    else
      status_rd_prev <= tmo_status_rd_i;
  end

  // clear at end of status read
  // clear only on write of one
  assign tmo_clear = share_reg[fbp_pkg::FBP_TMO_SEL_BIT]
                     ? tmo_write_one_i
                     : (status_rd_prev && !tmo_status_rd_i);

  // a new timeout in the clearing cycle wins, so no event is lost
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      tmo_flag_o <= 1'b0;
    else if (tmo_event_i)
      tmo_flag_o <= 1'b1;
    else if (tmo_clear)
      tmo_flag_o <= 1'b0;
  end

endmodule : fbp_regs

// >>> fbp_regs_monitor.sv
// assertion checker for the floppy base and sharing registers
`timescale 1ns/1ps
module fbp_regs_monitor (
  input wire logic clk_i,                   // system clock
  input wire logic resetn_i,                // reset, active low
  input wire fbp_pkg::fbp_cfg_req_t cfg_i,  // config access
  input wire fbp_pkg::fbp_io_req_t io_i,    // host io cycle
  input wire logic tmo_event_i,             // timeout set
  input wire logic tmo_status_rd_i,         // status read level
  input wire logic tmo_write_one_i,         // write of one
  input wire logic [7:0] rdata_o,           // read data
  input wire logic rd_hit_o,                // read hit
  input wire logic fdc_sel_o,               // floppy select
  input wire logic [2:0] fdc_reg_o,         // floppy register
  input wire fbp_pkg::fbp_route_t route_o,  // pin routing
  input wire logic tmo_flag_o               // timeout flag
);
  // everything here is one domain, so one clock and one reset
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // shadow of the index and clear select, rebuilt from port traffic only
  logic [7:0] seen_index;
  logic seen_sel;

  // index follows every accepted index write
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      seen_index <= fbp_pkg::FBP_INDEX_RESET;
    else if (cfg_i.cfg_active && cfg_i.index_wr)
      seen_index <= cfg_i.wdata;
  end

  // select bit follows accepted writes to the sharing register
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      seen_sel <= 1'b0;
    else if (cfg_i.cfg_active && cfg_i.data_wr
             && seen_index == fbp_pkg::FBP_IDX_SHARE)
      seen_sel <= cfg_i.wdata[fbp_pkg::FBP_TMO_SEL_BIT];
  end

  access_gate_a:
    assert property (rd_hit_o |-> $past(cfg_i.data_rd && cfg_i.cfg_active))
    else $error("read hit without config read");
  quiet_read_a:
    assert property (!rd_hit_o |-> rdata_o == 8'h00)
    else $error("read data without hit");
  fixed_zero_a:
    assert property (rd_hit_o && $past(seen_index) == fbp_pkg::FBP_IDX_BASE
      |-> rdata_o[1:0] == 2'h0)
    else $error("base read-only bits not zero");
  share_high_zero_a:
    assert property (rd_hit_o && $past(seen_index) == fbp_pkg::FBP_IDX_SHARE
      |-> rdata_o[7:3] == 5'h00)
    else $error("sharing read-only bits not zero");
  high_addr_a:
    assert property (io_i.valid && (io_i.addr[15:10] != 6'h00 || io_i.addr[3])
      |=> !fdc_sel_o)
    else $error("select outside the window");
  base_off_a:
    assert property (fdc_sel_o |-> $past(io_i.addr[9:8]) != 2'h0)
    else $error("select while decoding is off");
  reg_pick_a:
    assert property (fdc_sel_o |-> fdc_reg_o == $past(io_i.addr[2:0]))
    else $error("wrong internal register");
  tmo_set_a:
    assert property (tmo_event_i |=> tmo_flag_o)
    else $error("timeout flag not set");
  tmo_clear_a:
    assert property ($fell(tmo_flag_o) |-> ($past(seen_sel)
      ? $past(tmo_write_one_i)
      : ($past(tmo_status_rd_i, 2) && !$past(tmo_status_rd_i))))
    else $error("timeout flag cleared without cause");
  route_shape_a:
    assert property (route_o.drive0_on_pp |->
      route_o.drive1_on_pp && route_o.pp_is_floppy)
    else $error("drive 0 on port without drive 1");
endmodule : fbp_regs_monitor

bind fbp_regs fbp_regs_monitor mon (.clk_i(clk_i), .resetn_i(resetn_i),
  .cfg_i(cfg_i), .io_i(io_i), .tmo_event_i(tmo_event_i),
  .tmo_status_rd_i(tmo_status_rd_i), .tmo_write_one_i(tmo_write_one_i),
  .rdata_o(rdata_o), .rd_hit_o(rd_hit_o), .fdc_sel_o(fdc_sel_o),
  .fdc_reg_o(fdc_reg_o), .route_o(route_o), .tmo_flag_o(tmo_flag_o));

// >>> testbench.sv
// self-checking bench for the floppy base and sharing registers
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [15:0] addr;
    logic sel;
  } fbp_row_t;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  fbp_pkg::fbp_cfg_req_t cfg_i = '0;
  fbp_pkg::fbp_io_req_t io_i = '0;
  logic share_pin_i = 1'b1;
  logic pp_mode_floppy_i = 1'b0;
  logic [2:0] tmo_t = 3'h0; // event, status read, write one
  logic act = 1'b1;
  logic [7:0] rdata_o;
  logic rd_hit_o, fdc_sel_o, tmo_flag_o;
  logic [2:0] fdc_reg_o;
  fbp_pkg::fbp_route_t route_o;
  int mismatches = 0;
  int total_checks = 0;
  // write, read back, then one io cycle against the new base
  fbp_row_t rows [8] = '{
    '{8'h20, 8'hFC, 8'hFC, 16'h03F5, 1'b1},
    '{8'h20, 8'hFC, 8'hFC, 16'h03F8, 1'b0},
    '{8'h20, 8'hFC, 8'hFC, 16'h07F0, 1'b0},
    '{8'h20, 8'h43, 8'h40, 16'h0107, 1'b1},
    '{8'h20, 8'h00, 8'h00, 16'h0000, 1'b0},
    '{8'h20, 8'hFF, 8'hFC, 16'h03F0, 1'b1},
    '{8'h21, 8'hFD, 8'h05, 16'h03F0, 1'b1},
    '{8'h22, 8'h55, 8'h00, 16'h03F1, 1'b1}};

  fbp_regs DUT (.clk_i(clk_i), .resetn_i(resetn_i), .cfg_i(cfg_i),
    .io_i(io_i), .share_pin_i(share_pin_i),
    .pp_mode_floppy_i(pp_mode_floppy_i), .tmo_event_i(tmo_t[2]),
    .tmo_status_rd_i(tmo_t[1]), .tmo_write_one_i(tmo_t[0]),
    .rdata_o(rdata_o), .rd_hit_o(rd_hit_o), .fdc_sel_o(fdc_sel_o),
    .fdc_reg_o(fdc_reg_o), .route_o(route_o), .tmo_flag_o(tmo_flag_o));

  // 20 MHz clock
  always #25 clk_i = ~clk_i;

  ////////////////////////////////////////
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // k is index write, data write, data read; act gates the whole access
  task cyc(input logic [2:0] k, input logic [7:0] d);
    @(posedge clk_i);
    cfg_i <= '{act, k[2], k[1], k[0], d};
  endtask : cyc

  task wr(input logic [7:0] i, input logic [7:0] d);
    cyc(3'h4, i);
    cyc(3'h2, d);
    cyc(3'h0, 8'h00);
  endtask : wr

  task rd(input logic [7:0] i, input logic [7:0] e, input logic h);
    cyc(3'h4, i);
    cyc(3'h1, 8'h00);
    cyc(3'h0, 8'h00);
    #1;
    chk(rdata_o, e);
    chk({7'h00, rd_hit_o}, {7'h00, h});
  endtask : rd

  task io(input logic [15:0] a, input logic s);
    @(posedge clk_i);
    io_i <= '{1'b1, a};
    @(posedge clk_i);
    io_i <= '0;
    #1;
    chk({7'h00, fdc_sel_o}, {7'h00, s});
    if (s)
      chk({5'h00, fdc_reg_o}, {5'h00, a[2:0]});
  endtask : io

  // pin needs two edges through the synchroniser and one into route_o, so wait four
  task rt(input logic [7:0] f, input logic p, m, input logic [2:0] e);
    wr(8'h21, f);
    share_pin_i <= p;
    pp_mode_floppy_i <= m;
    repeat (4) @(posedge clk_i);
    #1;
    chk({5'h00, route_o}, {5'h00, e});
  endtask : rt

  task tm(input logic [2:0] t, input logic e);
    @(posedge clk_i);
    tmo_t <= t;
    #1;
    chk({7'h00, tmo_flag_o}, {7'h00, e});
  endtask : tm

  task tally_and_finish;
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    foreach (rows[n])
    begin
      wr(rows[n].idx, rows[n].wd);
      rd(rows[n].idx, rows[n].rd, rows[n].idx[7:1] == 7'h10);
      io(rows[n].addr, rows[n].sel);
    end
    act = 1'b0;
    wr(8'h20, 8'h00);
    act = 1'b1;
    rd(8'h20, 8'hFC, 1'b1);
    rt(8'h00, 1'b1, 1'b1, 3'h5);
    rt(8'h00, 1'b0, 1'b0, 3'h0);
    rt(8'h01, 1'b0, 1'b0, 3'h5);
    rt(8'h02, 1'b0, 1'b0, 3'h7);
    rt(8'h02, 1'b1, 1'b0, 3'h0);
    rt(8'h03, 1'b0, 1'b0, 3'h0);
    wr(8'h21, 8'h00);
    tm(3'h4, 1'b0);
    tm(3'h2, 1'b1);
    tm(3'h2, 1'b1);
    tm(3'h0, 1'b1);
    tm(3'h0, 1'b0);
    wr(8'h21, 8'h04);
    tm(3'h4, 1'b0);
    tm(3'h2, 1'b1);
    tm(3'h0, 1'b1);
    tm(3'h0, 1'b1);
    tm(3'h1, 1'b1);
    tm(3'h0, 1'b0);
    tm(3'h5, 1'b0);
    tm(3'h0, 1'b1);
    // second reset in mid-run, asserted on an edge like every other input
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk({7'h00, tmo_flag_o}, 8'h00);
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(8'h20, 8'h3C, 1'b1);
    rd(8'h21, 8'h00, 1'b1);
    // reset base has bits nine and eight clear, so decoding starts off
    io(16'h00F2, 1'b0);
    wr(8'h20, 8'h90);
    io(16'h0245, 1'b1);
    tally_and_finish;
  end

  // watchdog, far beyond the 155 or so cycles the tests need
  initial
  begin
    #500000;
    mismatches++;
    tally_and_finish;
  end
endmodule : testbench
